/* File: verilog/serial_eeprom_read_path.sv */
// Read side of a two-wire serial EEPROM slave with identification page and serial number
`timescale 1ns/1ps
module serial_eeprom_read_path #(
  parameter int ADDR_W = 13,
  parameter logic [127:0] SERIAL = 128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210 // Arbitrary
) (
  input wire logic clk, // System clock, 50 MHz
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic scl_clk, // Bus serial clock
  input wire logic sda_in, // Data line level
  output logic sda_out, // Data line drive value, always low
  output logic sda_oe_b, // Data line pull-down enable, active low
  input wire logic [2:0] chip_select_strap, // Chip enable straps, bit 2 down to 0
  input wire logic id_locked, // Identification page locked
  output logic [ADDR_W-1:0] mem_addr, // Array or page byte address
  output logic mem_id_sel, // Address selects identification page
  input wire logic [7:0] mem_rdata, // Byte at mem_addr, same cycle
  output logic standby // Device in standby
);
  if (ADDR_W < 9 || ADDR_W > serial_eeprom_read_pkg::ADDR_W_MAX) begin : g_bad_addr_w
    $error("ADDR_W out of range");
  end
  typedef struct packed {
    logic tgl;
    logic bit_v;
  } link_t;
  typedef struct packed {
    serial_eeprom_read_pkg::state_t st;
    serial_eeprom_read_pkg::state_t from;
    serial_eeprom_read_pkg::region_t rg;
    logic [7:0] sh;
    logic [3:0] bcnt;
    logic [ADDR_W-1:0] ptr;
    logic rd;
    logic spec;
    logic done;
    logic ack;
    logic more;
    logic oe_b;
    logic [2:0] scl_s;
    logic [2:0] sda_s;
    logic [2:0] tg_s;
    logic [2:0] strap_a;
    logic [2:0] strap_b;
  } core_t;
  link_t lq;
  link_t ln;
  core_t q;
  core_t n;
  logic [1:0] lrst;
  function automatic logic [ADDR_W-1:0] adv(input logic [ADDR_W-1:0] p,
                                           input serial_eeprom_read_pkg::region_t r);
    logic [ADDR_W-1:0] v;
    v = p + 1'b1;
    if (r == serial_eeprom_read_pkg::RG_IDPG) begin
      v = '0;
      v[serial_eeprom_read_pkg::ID_OFS_W-1:0] = p[serial_eeprom_read_pkg::ID_OFS_W-1:0] + 1'b1;
    end else if (r == serial_eeprom_read_pkg::RG_SN) begin
      v = p;
      v[serial_eeprom_read_pkg::SN_OFS_W-1:0] = p[serial_eeprom_read_pkg::SN_OFS_W-1:0] + 1'b1;
    end
    return v;
  endfunction
  function automatic logic [7:0] fetch(input logic [ADDR_W-1:0] p,
                                       input serial_eeprom_read_pkg::region_t r,
                                       input logic [7:0] md);
    logic [3:0] idx;
    idx = p[serial_eeprom_read_pkg::SN_OFS_W-1:0];
    unique case (r)
      serial_eeprom_read_pkg::RG_SN: fetch = SERIAL[(4'hf - idx) * 8 +: 8];
      serial_eeprom_read_pkg::RG_LOCK: fetch = serial_eeprom_read_pkg::UNDEF_BYTE;
      default: fetch = md;
    endcase
  endfunction
  // Link side: capture each data bit at the clock rise
  always_comb begin
    ln.tgl = ~lq.tgl;
    ln.bit_v = sda_in;
  end
  always_ff @(posedge scl_clk) begin
    lrst <= {lrst[0], rst_b};
    if (!lrst[1]) begin
      lq <= '0;
    end else begin
      lq <= ln;
    end
  end
  logic scl_hi;
  logic scl_fall;
  logic start_ev;
  logic stop_ev;
  logic bit_ev;
  logic match;
  logic ld;
  logic [7:0] sh_in;
  logic [7:0] fetched;
  always_comb begin
    n = q;
    n.scl_s = {q.scl_s[1:0], scl_clk};
    n.sda_s = {q.sda_s[1:0], sda_in};
    n.tg_s = {q.tg_s[1:0], lq.tgl};
    n.strap_a = chip_select_strap;
    n.strap_b = q.strap_a;
    scl_hi = q.scl_s[1];
    scl_fall = q.scl_s[2] & ~q.scl_s[1];
    start_ev = scl_hi & q.sda_s[2] & ~q.sda_s[1];
    stop_ev = scl_hi & ~q.sda_s[2] & q.sda_s[1];
    bit_ev = q.tg_s[2] ^ q.tg_s[1];
    sh_in = {q.sh[6:0], lq.bit_v};
    match = (sh_in[7:4] == serial_eeprom_read_pkg::TYPE_MAIN
          || sh_in[7:4] == serial_eeprom_read_pkg::TYPE_SPEC)
          && sh_in[serial_eeprom_read_pkg::CE_LSB +: 3] == q.strap_b;
    fetched = fetch(q.ptr, q.rg, mem_rdata);
    ld = scl_fall && !start_ev && !stop_ev
      && ((q.st == serial_eeprom_read_pkg::ST_ACK && q.from == serial_eeprom_read_pkg::ST_DEV
           && q.rd) || (q.st == serial_eeprom_read_pkg::ST_MACK && q.more));
    if (start_ev) begin
      n.st = serial_eeprom_read_pkg::ST_DEV;
      n.bcnt = '0;
      n.done = 1'b0;
      n.oe_b = 1'b1;
    end else if (stop_ev) begin
      n.st = serial_eeprom_read_pkg::ST_IDLE;
      n.oe_b = 1'b1;
    end else if (ld) begin
      n.sh = fetched;
      n.ptr = adv(q.ptr, q.rg);
      n.oe_b = fetched[7];
      n.bcnt = serial_eeprom_read_pkg::FIRST_TX_BIT;
      n.st = serial_eeprom_read_pkg::ST_TX;
    end else begin
      unique case (q.st)
        serial_eeprom_read_pkg::ST_IDLE: ;
        serial_eeprom_read_pkg::ST_DEV, serial_eeprom_read_pkg::ST_WHI,
        serial_eeprom_read_pkg::ST_WLO, serial_eeprom_read_pkg::ST_WDATA: begin
          if (bit_ev && !q.done) begin
            n.sh = sh_in;
            n.bcnt = q.bcnt + 1'b1;
            if (q.bcnt == serial_eeprom_read_pkg::LAST_RX_BIT) begin
              n.done = 1'b1;
              n.ack = 1'b1;
              if (q.st == serial_eeprom_read_pkg::ST_DEV) begin
                n.ack = match;
              end else if (q.st == serial_eeprom_read_pkg::ST_WDATA
                           && q.rg == serial_eeprom_read_pkg::RG_IDPG) begin
                n.ack = ~id_locked;
              end
            end
          end
          if (scl_fall && q.done) begin
            n.done = 1'b0;
            n.bcnt = '0;
            n.from = q.st;
            n.st = q.ack ? serial_eeprom_read_pkg::ST_ACK : serial_eeprom_read_pkg::ST_IDLE;
            n.oe_b = ~q.ack;
            unique case (q.st)
              serial_eeprom_read_pkg::ST_DEV: begin
                n.rd = q.sh[serial_eeprom_read_pkg::RW_BIT];
                n.spec = (q.sh[7:4] == serial_eeprom_read_pkg::TYPE_SPEC);
                if (q.sh[7:4] == serial_eeprom_read_pkg::TYPE_MAIN) begin
                  n.rg = serial_eeprom_read_pkg::RG_MAIN;
                end
              end
              serial_eeprom_read_pkg::ST_WHI: begin
                n.ptr[ADDR_W-1:8] = q.sh[ADDR_W-9:0];
                if (!q.spec) begin
                  n.rg = serial_eeprom_read_pkg::RG_MAIN;
                end else if (q.sh[serial_eeprom_read_pkg::SEL_LO_BIT +: 2]
                             == serial_eeprom_read_pkg::SEL_IDPG) begin
                  n.rg = serial_eeprom_read_pkg::RG_IDPG;
                end else if (q.sh[serial_eeprom_read_pkg::SEL_LO_BIT +: 2]
                             == serial_eeprom_read_pkg::SEL_SN) begin
                  n.rg = serial_eeprom_read_pkg::RG_SN;
                end else begin
                  n.rg = serial_eeprom_read_pkg::RG_LOCK;
                end
              end
              serial_eeprom_read_pkg::ST_WLO: begin
                n.ptr[7:0] = q.sh;
                if (q.rg == serial_eeprom_read_pkg::RG_IDPG) begin
                  n.ptr[ADDR_W-1:serial_eeprom_read_pkg::ID_OFS_W] = '0;
                end
              end
              default: begin
                n.ptr = adv(q.ptr, q.rg);
              end
            endcase
          end
        end
        serial_eeprom_read_pkg::ST_ACK: begin
          if (scl_fall) begin
            n.oe_b = 1'b1;
            unique case (q.from)
              serial_eeprom_read_pkg::ST_DEV: n.st = serial_eeprom_read_pkg::ST_WHI;
              serial_eeprom_read_pkg::ST_WHI: n.st = serial_eeprom_read_pkg::ST_WLO;
              default: n.st = serial_eeprom_read_pkg::ST_WDATA;
            endcase
          end
        end
        serial_eeprom_read_pkg::ST_TX: begin
          if (scl_fall) begin
            if (q.bcnt == serial_eeprom_read_pkg::TX_BITS) begin
              n.oe_b = 1'b1;
              n.more = 1'b0;
              n.bcnt = '0;
              n.st = serial_eeprom_read_pkg::ST_MACK;
            end else begin
              n.sh = {q.sh[6:0], 1'b0};
              n.oe_b = q.sh[6];
              n.bcnt = q.bcnt + 1'b1;
            end
          end
        end
        serial_eeprom_read_pkg::ST_MACK: begin
          if (bit_ev) begin
            n.more = ~lq.bit_v;
          end
          if (scl_fall) begin
            n.st = serial_eeprom_read_pkg::ST_IDLE;
          end
        end
      endcase
    end
  end
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      q <= '{st: serial_eeprom_read_pkg::ST_IDLE, from: serial_eeprom_read_pkg::ST_IDLE,
             rg: serial_eeprom_read_pkg::RG_MAIN, oe_b: 1'b1, scl_s: 3'h7, sda_s: 3'h7,
             default: '0};
    end else begin
      q <= n;
    end
  end
  assign sda_out = 1'b0;
  assign sda_oe_b = q.oe_b;
  assign mem_addr = q.ptr;
  assign mem_id_sel = (q.rg == serial_eeprom_read_pkg::RG_IDPG);
  assign standby = (q.st == serial_eeprom_read_pkg::ST_IDLE);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  sequence nack_seen_s;
    q.st == serial_eeprom_read_pkg::ST_MACK && !q.more && scl_fall && !start_ev && !stop_ev;
  endsequence
  sequence load_s;
    ld;
  endsequence
  stop_standby_a: assert property (stop_ev && !start_ev |=> standby && sda_oe_b)
    else $error("STOP did not return to standby");
  nack_release_a: assert property (nack_seen_s |=> sda_oe_b ##1 sda_oe_b)
    else $error("Line still driven after no acknowledge");
  ptr_advance_a: assert property (load_s |=> q.ptr == adv($past(q.ptr), q.rg))
    else $error("Pointer did not advance on byte load");
  main_wrap_a: assert property (load_s and q.rg == serial_eeprom_read_pkg::RG_MAIN
    && &q.ptr |=> q.ptr == '0)
    else $error("Array pointer did not wrap");
  sn_wrap_a: assert property (load_s and q.rg == serial_eeprom_read_pkg::RG_SN
    && &q.ptr[3:0] |=> q.ptr[3:0] == 4'h0 && q.ptr[ADDR_W-1:4] == $past(q.ptr[ADDR_W-1:4]))
    else $error("Serial pointer did not wrap to start");
  page_offset_a: assert property (q.st == serial_eeprom_read_pkg::ST_TX && mem_id_sel
    |-> q.ptr[ADDR_W-1:serial_eeprom_read_pkg::ID_OFS_W] == '0)
    else $error("Page pointer left its page");
  lock_ack_a: assert property (q.st == serial_eeprom_read_pkg::ST_WDATA && q.done
    && scl_fall && mem_id_sel && !start_ev && !stop_ev |=> sda_oe_b == $past(id_locked, 2))
    else $error("Lock check acknowledge wrong");
  addr_match_a: assert property (q.st == serial_eeprom_read_pkg::ST_DEV && q.done
    && scl_fall && !start_ev && !stop_ev && (q.sh[3:1] != q.strap_b || q.sh[7:4] != 4'ha
    && q.sh[7:4] != 4'hb) |=> sda_oe_b && standby) else $error("Foreign address acknowledged");
  msb_first_a: assert property (load_s ##1 (q.st == serial_eeprom_read_pkg::ST_TX)
    |-> sda_oe_b == q.sh[7])
    else $error("First bit sent is not MSB");
  ack_release_a: assert property (q.st == serial_eeprom_read_pkg::ST_MACK |-> sda_oe_b)
    else $error("Line driven during master acknowledge");
  sn_fixed_a: assert property (load_s and q.rg == serial_eeprom_read_pkg::RG_SN
    |=> q.sh == SERIAL[(4'hf - $past(q.ptr[3:0])) * 8 +: 8])
    else $error("Serial byte differs from fixed value");
  ptr_hold_a: assert property (standby && !start_ev |=> q.ptr == $past(q.ptr))
    else $error("Pointer moved in standby");
endmodule // serial_eeprom_read_path

/* File: verilog/serial_eeprom_read_pkg.sv */
// Constants and types shared by the serial EEPROM read path
package serial_eeprom_read_pkg;
  typedef enum logic [7:0] {
    ST_IDLE  = 8'h01,
    ST_DEV   = 8'h02,
    ST_WHI   = 8'h04,
    ST_WLO   = 8'h08,
    ST_WDATA = 8'h10,
    ST_ACK   = 8'h20,
    ST_TX    = 8'h40,
    ST_MACK  = 8'h80
  } state_t;

  typedef enum logic [1:0] {
    RG_MAIN = 2'h0,
    RG_IDPG = 2'h1,
    RG_SN   = 2'h2,
    RG_LOCK = 2'h3
  } region_t;

  localparam logic [3:0] TYPE_MAIN = 4'ha;
  localparam logic [3:0] TYPE_SPEC = 4'hb;
  localparam int RW_BIT = 0;
  localparam int CE_LSB = 1;
  localparam int SEL_LO_BIT = 2;
  localparam logic [1:0] SEL_IDPG = 2'h0;
  localparam logic [1:0] SEL_SN = 2'h2;
  localparam int ID_OFS_W = 5;
  localparam int SN_OFS_W = 4;
  localparam int HI_ADDR_BITS = 5;
  localparam logic [3:0] LAST_RX_BIT = 4'h7;
  localparam logic [3:0] TX_BITS = 4'h8;
  localparam logic [3:0] FIRST_TX_BIT = 4'h1;
  localparam logic [7:0] UNDEF_BYTE = 8'hff;
  localparam int ADDR_W_MAX = 13;
endpackage

/* File: verif/bus_master_model.sv */
// Two-wire bus master model: serial clock, open-drain data, transfer results
`timescale 1ns/1ps
module bus_master_model (
  input wire logic clk, // System clock
  input wire logic sda_line, // Resolved data line
  output logic scl_clk, // Serial clock, idle high
  output logic sda_m, // Master data drive, 1 = released
  output logic [8:0] res, // Last transfer as {ack bit, byte}
  output logic res_stb // One cycle per finished transfer
);
  initial begin
    scl_clk = 1'b1;
    sda_m = 1'b1;
    res = 9'h000;
    res_stb = 1'b0;
  end
  task automatic w(input int n);
    repeat (n) @(posedge clk);
  endtask
  // Serial clock offset from clk edges so the two stay unrelated
  task automatic clk_bit(input logic b, output logic s);
    w(5);
    sda_m <= b;
    w(5);
    scl_clk <= #7 1'b1;
    w(5);
    s = sda_line;
    w(5);
    scl_clk <= #7 1'b0;
  endtask
  task automatic rst_toggle();
    repeat (4) begin
      scl_clk <= #7 1'b0;
      w(1);
      scl_clk <= #7 1'b1;
      w(1);
    end
  endtask
  task automatic start();
    w(5);
    sda_m <= 1'b1;
    w(5);
    scl_clk <= #7 1'b1;
    w(5);
    sda_m <= 1'b0;
    w(5);
    scl_clk <= #7 1'b0;
  endtask
  task automatic stop();
    w(5);
    sda_m <= 1'b0;
    w(5);
    scl_clk <= #7 1'b1;
    w(5);
    sda_m <= 1'b1;
    w(5);
  endtask
  // Read: line sampled in the ack slot shows the master ack and a released device
  task automatic xfer(input logic rd, input logic [7:0] d, input logic ack);
    logic [7:0] got;
    logic a;
    for (int i = 7; i >= 0; i--) begin
      clk_bit(rd ? 1'b1 : d[i], got[i]);
    end
    clk_bit(rd ? ack : 1'b1, a);
    res <= {a, rd ? got : d};
    res_stb <= 1'b1;
    w(1);
    res_stb <= 1'b0;
  endtask
endmodule // bus_master_model

/* File: verif/serial_eeprom_read_path_bench.sv */
// Self-checking bench for the serial EEPROM read path
`timescale 1ns/1ps
module serial_eeprom_read_path_bench;
  localparam logic [127:0] SN = 128'h5a3c_96e1_0f7b_28d4_c3a9_61e8_7b02_f4d5; // Arbitrary
  logic clk, rst_b, scl_clk, sda_m, sda_out, sda_oe_b, id_locked, mem_id_sel, standby;
  logic sda_line, res_stb;
  logic [2:0] chip_select_strap;
  logic [12:0] mem_addr;
  logic [7:0] mem_rdata;
  logic [8:0] res;
  logic [8:0] expq[$];
  logic [31:0] lfsr = 32'he06e4bc0;
  int fail_count = 0, tests_run = 0, cycles = 0, ptr = 0, rg = 0;
  assign sda_line = sda_m & (sda_oe_b | sda_out);
  assign mem_rdata = mem_id_sel ? {3'h5, mem_addr[4:0]} : mem_addr[7:0] ^ {3'h0, mem_addr[12:8]};
  serial_eeprom_read_path #(.ADDR_W(13), .SERIAL(SN)) DUT (.clk(clk), .rst_b(rst_b),
    .scl_clk(scl_clk), .sda_in(sda_line), .sda_out(sda_out), .sda_oe_b(sda_oe_b),
    .chip_select_strap(chip_select_strap), .id_locked(id_locked), .mem_addr(mem_addr),
    .mem_id_sel(mem_id_sel), .mem_rdata(mem_rdata), .standby(standby));
  bus_master_model m (.clk(clk), .sda_line(sda_line), .scl_clk(scl_clk), .sda_m(sda_m),
    .res(res), .res_stb(res_stb));
  function automatic logic [31:0] nx(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic logic [7:0] exp_byte(input int r, input int p);
    case (r)
      0: return p[7:0] ^ {3'h0, p[12:8]};
      1: return {3'h5, p[4:0]};
      2: return SN[127 - 8 * p[3:0] -: 8];
      default: return 8'hff;
    endcase
  endfunction
  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("fail_count %0d tests_run %0d", fail_count, tests_run);
    if (fail_count == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic xf(input logic rd, input logic [7:0] d, input logic a, input logic [7:0] e);
    expq.push_back({a, e});
    m.xfer(rd, d, a);
  endtask
  task automatic dev(input logic spec, input logic [2:0] cs, input logic rw, input logic ok);
    xf(1'b0, {spec ? serial_eeprom_read_pkg::TYPE_SPEC : serial_eeprom_read_pkg::TYPE_MAIN,
      cs, rw}, !ok, {spec ? 4'hb : 4'ha, cs, rw});
  endtask
  task automatic set_ptr(input logic spec, input logic [7:0] hi, lo, input int r, p);
    m.start();
    dev(spec, chip_select_strap, 1'b0, 1'b1);
    xf(1'b0, hi, 1'b0, hi);
    xf(1'b0, lo, 1'b0, lo);
    rg = r;
    ptr = p;
  endtask
  task automatic read(input logic spec, input int n);
    m.start();
    dev(spec, chip_select_strap, 1'b1, 1'b1);
    for (int i = 0; i < n; i++) begin
      xf(1'b1, 8'h00, i == n - 1, exp_byte(rg, ptr));
      ptr = rg == 0 ? (ptr + 1) % 8192 : rg == 1 ? (ptr + 1) & 31 : 'h800 | ((ptr + 1) & 15);
    end
    m.stop();
    check({8'h00, standby}, 9'h001);
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      fail_count++;
      stop_test();
    end
    if (res_stb) begin
      check(res, expq.size() > 0 ? expq.pop_front() : 9'h1ff);
    end
  end
  initial begin
    rst_b <= 1'b0;
    id_locked <= 1'b0;
    chip_select_strap <= lfsr[2:0];
    m.rst_toggle();
    rst_b <= 1'b1;
    // Serial clock edges flush the link side reset synchroniser
    m.rst_toggle();
    m.w(6);
    repeat (2) begin
      lfsr = nx(lfsr);
      set_ptr(1'b0, lfsr[15:8], lfsr[7:0], 0, lfsr[12:0]);
      read(1'b0, 3);
    end
    set_ptr(1'b0, 8'h1f, 8'hff, 0, 8191);
    read(1'b0, 2);
    read(1'b0, 2);
    set_ptr(1'b1, 8'hf3, 8'hfe, 1, 30);
    read(1'b1, 2);
    set_ptr(1'b1, 8'h08, 8'h00, 2, 'h800);
    read(1'b1, 17);
    read(1'b1, 1);
    set_ptr(1'b1, 8'h04, 8'h00, 3, 0);
    read(1'b1, 1);
    for (int lk = 0; lk < 2; lk++) begin
      id_locked <= lk[0];
      set_ptr(1'b1, 8'h00, 8'h00, 1, 0);
      xf(1'b0, 8'h5a, lk[0], 8'h5a);
      m.stop();
    end
    m.start();
    dev(1'b0, ~chip_select_strap, 1'b1, 1'b0);
    m.stop();
    m.w(4);
    stop_test();
  end
endmodule // serial_eeprom_read_path_bench
